// File: include/ccm_defs.svh
`ifndef CCM_DEFS_SVH
`define CCM_DEFS_SVH

// register port addresses, one per slot
`define CCM_ADDR_SLOT_BASE 8'h03
`define CCM_ADDR_SLOT_LAST 8'h05

// sub-register indices
`define CCM_IDX_CTRL 2'h0
`define CCM_IDX_SHORT 2'h1
`define CCM_IDX_LONG_HIGH 2'h2
`define CCM_IDX_LONG_LOW 2'h3

// clock control field positions
`define CCM_BIT_RST_LEVEL 6
`define CCM_POS_CLKPD 2
`define CCM_POS_DIV 0

// reset values
`define CCM_RST_CTRL 5'h00
`define CCM_RST_SHORT 8'haa
`define CCM_RST_LONG_HIGH 8'ha4
`define CCM_RST_LONG_LOW 8'h74

// input clock cycles withheld at activation
`define CCM_SKIP_DIV1 3'h4
`define CCM_SKIP_OTHER 3'h5

// half periods of the card clock, in input clock edges
`define CCM_HALF_DIV1 3'h1
`define CCM_HALF_DIV2 3'h2
`define CCM_HALF_DIV4 3'h4
`define CCM_HALF_DIV5 3'h5

`endif

// File: include/ccm_pkg.sv
package ccm_pkg;

   typedef enum logic {
      CCM_SYNC,
      CCM_ASYNC
   } ccm_mode_t;

   typedef struct packed {
      logic rst_level;
      logic [1:0] clkpd;
      logic [1:0] div;
   } ccm_ctrl_t;

   typedef struct packed {
      logic start;
      logic power_down_clock_select;
      logic [1:0] reg_sel;
      logic atr_rst;
   } ccm_slot_in_t;

endpackage

// File: src/ccm_slot_clock.sv
`timescale 1ns/100ps
`include "ccm_defs.svh"

// Summary of operation
// - async with power-down select 1: card clock taken from clock power-down field bits 3:2
// - sync with select and start 1: upper power-down bit held 0, lower bit rules
// - async field 00 stops clock low, 01 stops clock high
// - async field 10 gives half the internal oscillator frequency
// - async field 11 leaves the clock to the external divider field
// - sync mode, select 1: clock static low for controlling bit 0, high for 1
// - sync mode: hardware forces both divider bits to 0
// - async, select 0: external clock divided by 1, 2, 4 or 5
// - sub-register index 00 control, 01 short counter, 10 long high, 11 long low
// - shared 8-bit answer counter value, read/write, resets to AAh
// - shared long counter high byte, read/write, resets to A4h
// - shared long counter low byte, read/write, resets to 74h
// - start rising edge samples reset level bit: 1 async, else sync
// - async mode: card reset pin driven by the answer counter
// - sync mode: card reset pin follows the reset level bit
// - sync mode: clock set by power-down select captured at start rise
// - power-down select 1 uses power-down field, 0 uses divider field
// - activation withholds 4 input cycles in sync mode or for async div 00, else 5
// - new division ratio applies only after the next rising card clock edge
module ccm_slot_clock #(
   parameter int NUM_SLOTS = 3
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [7:0] acc_addr,
   input wire logic acc_wr,
   input wire logic [7:0] acc_wdata,
   output logic [7:0] acc_rdata,
   input ccm_pkg::ccm_slot_in_t slot_in [NUM_SLOTS],
   input wire logic slots_2_to_5_clock_input,
   input wire logic osc_int,
   output logic [NUM_SLOTS-1:0] card_clk,
   output logic [NUM_SLOTS-1:0] card_rst,
   output logic [7:0] atr_short_preload,
   output logic [15:0] atr_long_preload
);
   import ccm_pkg::*;

   function automatic logic [2:0] half_len(input logic [1:0] div);
      case (div)
         2'h0: half_len = `CCM_HALF_DIV1;
         2'h1: half_len = `CCM_HALF_DIV2;
         2'h2: half_len = `CCM_HALF_DIV4;
         default: half_len = `CCM_HALF_DIV5;
      endcase
   endfunction

   // shared input edge detection and oscillator halving
   logic ext_q;
   logic osc_q;
   logic osc_half;
   logic next_osc_half;
   logic ext_edge;
   logic ext_fall;

   always_comb begin
      ext_edge = slots_2_to_5_clock_input != ext_q;
      ext_fall = ext_q && !slots_2_to_5_clock_input;
      next_osc_half = osc_half;
      if (osc_int && !osc_q) begin
         next_osc_half = !osc_half;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ext_q <= 1'b0;
         osc_q <= 1'b0;
         osc_half <= 1'b0;
      end else begin
         ext_q <= slots_2_to_5_clock_input;
         osc_q <= osc_int;
         osc_half <= next_osc_half;
      end
   end

   // address decode
   logic slot_ok;
   logic [7:0] slot_off;
   logic [1:0] acc_sel;

   always_comb begin
      slot_ok = acc_addr >= `CCM_ADDR_SLOT_BASE && acc_addr <= `CCM_ADDR_SLOT_LAST;
      slot_off = acc_addr - `CCM_ADDR_SLOT_BASE;
      acc_sel = `CCM_IDX_CTRL;
      for (int k = 0; k < NUM_SLOTS; k++) begin
         if (slot_ok && slot_off == 8'(k)) begin
            acc_sel = slot_in[k].reg_sel;
         end
      end
   end

   // shared answer counter preload values
   logic [7:0] atr_short;
   logic [7:0] atr_high;
   logic [7:0] atr_low;
   logic [7:0] next_atr_short;
   logic [7:0] next_atr_high;
   logic [7:0] next_atr_low;

   always_comb begin
      next_atr_short = atr_short;
      next_atr_high = atr_high;
      next_atr_low = atr_low;
      if (acc_wr && slot_ok) begin
         case (acc_sel)
            `CCM_IDX_SHORT: next_atr_short = acc_wdata;
            `CCM_IDX_LONG_HIGH: next_atr_high = acc_wdata;
            `CCM_IDX_LONG_LOW: next_atr_low = acc_wdata;
            default: next_atr_short = atr_short;
         endcase
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         atr_short <= `CCM_RST_SHORT;
         atr_high <= `CCM_RST_LONG_HIGH;
         atr_low <= `CCM_RST_LONG_LOW;
      end else begin
         atr_short <= next_atr_short;
         atr_high <= next_atr_high;
         atr_low <= next_atr_low;
      end
   end

   assign atr_short_preload = atr_short;
   assign atr_long_preload = {atr_high, atr_low};

   // per-slot state
   ccm_ctrl_t ctrl [NUM_SLOTS];
   ccm_mode_t mode [NUM_SLOTS];
   logic [NUM_SLOTS-1:0] start_q;
   logic [NUM_SLOTS-1:0] power_down_clock_select_cap;
   logic [1:0] act_div [NUM_SLOTS];
   logic [2:0] edge_cnt [NUM_SLOTS];
   logic [2:0] skip_cnt [NUM_SLOTS];
   logic [2:0] skip_lim [NUM_SLOTS];
   logic [NUM_SLOTS-1:0] ext_clk;
   logic [NUM_SLOTS-1:0] clk_out;
   logic [NUM_SLOTS-1:0] rst_out;

   for (genvar i = 0; i < NUM_SLOTS; i++) begin : g_slot
      ccm_ctrl_t next_ctrl;
      ccm_mode_t next_mode;
      logic next_start_q;
      logic next_pcap;
      logic [1:0] next_div;
      logic [2:0] next_cnt;
      logic [2:0] next_skip;
      logic [2:0] next_lim;
      logic next_ext;
      logic next_clk_out;
      logic next_rst_out;
      logic activate;
      logic [1:0] sel_div;
      logic [2:0] cnt_inc;

      always_comb begin
         next_ctrl = ctrl[i];
         next_mode = mode[i];
         next_start_q = slot_in[i].start;
         next_pcap = power_down_clock_select_cap[i];
         next_div = act_div[i];
         next_cnt = edge_cnt[i];
         next_skip = skip_cnt[i];
         next_lim = skip_lim[i];
         next_ext = ext_clk[i];
         activate = slot_in[i].start && !start_q[i];
         cnt_inc = 3'(edge_cnt[i] + 3'h1);
         if (acc_wr && slot_ok && slot_off == 8'(i) && slot_in[i].reg_sel == `CCM_IDX_CTRL) begin
            next_ctrl.rst_level = acc_wdata[`CCM_BIT_RST_LEVEL];
            next_ctrl.clkpd = acc_wdata[`CCM_POS_CLKPD +: 2];
            next_ctrl.div = acc_wdata[`CCM_POS_DIV +: 2];
         end
         if (mode[i] == CCM_SYNC && start_q[i]) begin
            next_ctrl.div = 2'h0;
            if (power_down_clock_select_cap[i]) begin
               next_ctrl.clkpd[1] = 1'b0;
            end
         end
         sel_div = (mode[i] == CCM_SYNC) ? 2'h0 : ctrl[i].div;
         if (activate) begin
            next_mode = ctrl[i].rst_level ? CCM_ASYNC : CCM_SYNC;
            next_pcap = slot_in[i].power_down_clock_select;
            next_div = ctrl[i].rst_level ? ctrl[i].div : 2'h0;
            next_lim = (next_div == 2'h0) ? `CCM_SKIP_DIV1 : `CCM_SKIP_OTHER;
            next_skip = 3'h0;
            next_cnt = 3'h0;
            next_ext = 1'b0;
         end else if (!start_q[i]) begin
            next_ext = 1'b0;
            next_cnt = 3'h0;
         end else if (skip_cnt[i] < skip_lim[i]) begin
            next_ext = 1'b0;
            if (ext_fall) begin
               next_skip = 3'(skip_cnt[i] + 3'h1);
            end
         end else if (ext_edge) begin
            next_cnt = cnt_inc;
            if (cnt_inc >= half_len(act_div[i])) begin
               next_cnt = 3'h0;
               next_ext = !ext_clk[i];
               if (!ext_clk[i]) begin
                  next_div = sel_div;
               end
            end
         end
         next_clk_out = 1'b0;
         next_rst_out = 1'b0;
         if (start_q[i]) begin
            case (mode[i])
               CCM_SYNC: begin
                  next_rst_out = ctrl[i].rst_level;
                  next_clk_out = power_down_clock_select_cap[i] ? ctrl[i].clkpd[0] : ext_clk[i];
               end
               CCM_ASYNC: begin
                  next_rst_out = slot_in[i].atr_rst;
                  next_clk_out = ext_clk[i];
                  if (slot_in[i].power_down_clock_select) begin
                     case (ctrl[i].clkpd)
                        2'h0: next_clk_out = 1'b0;
                        2'h1: next_clk_out = 1'b1;
                        2'h2: next_clk_out = osc_half;
                        default: next_clk_out = ext_clk[i];
                     endcase
                  end
               end
               default: next_clk_out = 1'b0;
            endcase
         end
      end

      always_ff @(posedge sys_clk or posedge rst) begin
         if (rst) begin
            ctrl[i] <= `CCM_RST_CTRL;
            mode[i] <= CCM_SYNC;
            start_q[i] <= 1'b0;
            power_down_clock_select_cap[i] <= 1'b0;
            act_div[i] <= 2'h0;
            edge_cnt[i] <= 3'h0;
            skip_cnt[i] <= 3'h0;
            skip_lim[i] <= `CCM_SKIP_DIV1;
            ext_clk[i] <= 1'b0;
            clk_out[i] <= 1'b0;
            rst_out[i] <= 1'b0;
         end else begin
            ctrl[i] <= next_ctrl;
            mode[i] <= next_mode;
            start_q[i] <= next_start_q;
            power_down_clock_select_cap[i] <= next_pcap;
            act_div[i] <= next_div;
            edge_cnt[i] <= next_cnt;
            skip_cnt[i] <= next_skip;
            skip_lim[i] <= next_lim;
            ext_clk[i] <= next_ext;
            clk_out[i] <= next_clk_out;
            rst_out[i] <= next_rst_out;
         end
      end
   end

   assign card_clk = clk_out;
   assign card_rst = rst_out;

   // registered read data
   logic [7:0] next_rdata;

   always_comb begin
      next_rdata = 8'h00;
      if (slot_ok) begin
         case (acc_sel)
            `CCM_IDX_CTRL: begin
               for (int k = 0; k < NUM_SLOTS; k++) begin
                  if (slot_off == 8'(k)) begin
                     next_rdata[`CCM_BIT_RST_LEVEL] = ctrl[k].rst_level;
                     next_rdata[`CCM_POS_CLKPD +: 2] = ctrl[k].clkpd;
                     next_rdata[`CCM_POS_DIV +: 2] = ctrl[k].div;
                  end
               end
            end
            `CCM_IDX_SHORT: next_rdata = atr_short;
            `CCM_IDX_LONG_HIGH: next_rdata = atr_high;
            `CCM_IDX_LONG_LOW: next_rdata = atr_low;
            default: next_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         acc_rdata <= 8'h00;
      end else begin
         acc_rdata <= next_rdata;
      end
   end

endmodule

// File: sim/ccm_slot_clock_sva.sv
`timescale 1ns/100ps
module ccm_slot_clock_sva
   import ccm_pkg::*;
#(
   parameter int NUM_SLOTS = 3
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [7:0] acc_addr,
   input wire logic acc_wr,
   input wire logic [7:0] acc_wdata,
   input wire logic [7:0] acc_rdata,
   input ccm_pkg::ccm_slot_in_t slot_in [NUM_SLOTS],
   input wire logic slots_2_to_5_clock_input,
   input wire logic osc_int,
   input wire logic [NUM_SLOTS-1:0] card_clk,
   input wire logic [NUM_SLOTS-1:0] card_rst,
   input wire logic [7:0] atr_short_preload,
   input wire logic [15:0] atr_long_preload
);
   logic mapped;
   logic [1:0] sel;
   always_comb begin
      mapped = acc_addr >= 8'h03 && acc_addr <= 8'h05;
      sel = mapped ? slot_in[2'(acc_addr - 8'h03)].reg_sel : 2'h0;
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   property p_rst_vals;
      $fell(rst) |-> atr_short_preload == 8'haa && atr_long_preload == 16'ha474;
   endproperty
   a_rst_vals: assert property (p_rst_vals) else $error("bad reset value");
   property p_short_wr;
      acc_wr && mapped && sel == 2'h1 |=> atr_short_preload == $past(acc_wdata);
   endproperty
   a_short_wr: assert property (p_short_wr) else $error("short write lost");
   property p_high_wr;
      acc_wr && mapped && sel == 2'h2 |=> atr_long_preload[15:8] == $past(acc_wdata);
   endproperty
   a_high_wr: assert property (p_high_wr) else $error("high write lost");
   property p_low_wr;
      acc_wr && mapped && sel == 2'h3 |=> atr_long_preload[7:0] == $past(acc_wdata);
   endproperty
   a_low_wr: assert property (p_low_wr) else $error("low write lost");
   property p_unmapped_wr;
      acc_wr && !mapped |=> $stable(atr_short_preload) && $stable(atr_long_preload);
   endproperty
   a_unmapped_wr: assert property (p_unmapped_wr) else $error("stray write");
   property p_short_rd;
      mapped && sel == 2'h1 && !acc_wr |=> acc_rdata == $past(atr_short_preload);
   endproperty
   a_short_rd: assert property (p_short_rd) else $error("short read wrong");
   property p_unmapped_rd;
      !mapped |=> acc_rdata == 8'h00;
   endproperty
   a_unmapped_rd: assert property (p_unmapped_rd) else $error("unmapped read");
   property p_ctrl_rsvd;
      mapped && sel == 2'h0 |=> acc_rdata[7] == 1'b0 && acc_rdata[5:4] == 2'h0;
   endproperty
   a_ctrl_rsvd: assert property (p_ctrl_rsvd) else $error("reserved bit set");
   property p_idle;
      !slot_in[0].start [*3] |-> card_clk[0] == 1'b0 && card_rst[0] == 1'b0;
   endproperty
   a_idle: assert property (p_idle) else $error("output without start");
endmodule
bind ccm_slot_clock ccm_slot_clock_sva #(.NUM_SLOTS(NUM_SLOTS)) u_sva (.sys_clk(sys_clk),
   .rst(rst), .acc_addr(acc_addr), .acc_wr(acc_wr), .acc_wdata(acc_wdata),
   .acc_rdata(acc_rdata), .slot_in(slot_in), .slots_2_to_5_clock_input(slots_2_to_5_clock_input),
   .osc_int(osc_int), .card_clk(card_clk), .card_rst(card_rst),
   .atr_short_preload(atr_short_preload), .atr_long_preload(atr_long_preload));

// File: sim/ccm_clk_src.sv
`timescale 1ns/100ps
module ccm_clk_src (
   input wire logic sys_clk,
   input wire logic rst,
   output logic ext_clk,
   output logic osc_clk
);
   logic [1:0] ext_cnt;
   logic osc_div;
   // external clock period 6 cycles, oscillator period 4 cycles
   always_ff @(negedge sys_clk or posedge rst) begin
      if (rst) begin
         ext_cnt <= 2'h0;
         osc_div <= 1'b0;
         ext_clk <= 1'b0;
         osc_clk <= 1'b0;
      end else begin
         ext_cnt <= (ext_cnt == 2'h2) ? 2'h0 : ext_cnt + 2'h1;
         osc_div <= ~osc_div;
         ext_clk <= (ext_cnt == 2'h2) ? ~ext_clk : ext_clk;
         osc_clk <= osc_div ? ~osc_clk : osc_clk;
      end
   end
endmodule

// File: sim/ccm_slot_clock_tb_top.sv
`timescale 1ns/100ps
module ccm_slot_clock_tb_top;
   import ccm_pkg::*;
   logic sys_clk = 0, rst = 1, acc_wr = 0, ext_clk, osc_clk, pc;
   logic [7:0] acc_addr = 0, acc_wdata = 0, acc_rdata, sp;
   logic [2:0] card_clk, card_rst;
   logic [15:0] lp;
   ccm_slot_in_t slot_in [3] = '{default: '0};
   int err_total = 0, n_compared = 0, seed = 90075, i, n, s;
   logic [7:0] v [2];
   logic [7:0] tc [10] = '{8'h40, 8'h41, 8'h42, 8'h43, 8'h48, 8'h03, 8'h40, 8'h44, 8'h4d,
      8'h0c};
   logic tp [10] = '{0, 0, 0, 0, 1, 0, 1, 1, 1, 1};
   logic tl [10] = '{0, 0, 0, 0, 0, 0, 0, 1, 0, 1};
   int tper [10] = '{6, 12, 24, 30, 8, 6, 0, 0, 12, 0};
   always #10 sys_clk = ~sys_clk;
   ccm_clk_src u_src (.sys_clk(sys_clk), .rst(rst), .ext_clk(ext_clk), .osc_clk(osc_clk));
   ccm_slot_clock DUT (.sys_clk(sys_clk), .rst(rst), .acc_addr(acc_addr), .acc_wr(acc_wr),
      .acc_wdata(acc_wdata), .acc_rdata(acc_rdata), .slot_in(slot_in),
      .slots_2_to_5_clock_input(ext_clk), .osc_int(osc_clk), .card_clk(card_clk),
      .card_rst(card_rst), .atr_short_preload(sp), .atr_long_preload(lp));
   function automatic logic [7:0] exp_ctrl(input logic [7:0] d, input logic sy, input logic pw);
      return {2'b00 | d[6], 2'b00, d[3] & !(sy & pw), d[2], d[1:0] & {2{!sy}}};
   endfunction
   function automatic logic edges_ok(input int cnt, input int per);
      if (per == 0) return cnt == 0;
      return cnt >= 480 / per - 1 && cnt <= 480 / per + 1;
   endfunction
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_compared++;
      if (g !== e) begin
         err_total++;
         $display("wrong value %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic chk1(input string nm, input logic e, input logic g);
      chk(nm, {7'h0, e}, {7'h0, g});
   endtask
   task automatic wr(input logic [7:0] a, input logic [1:0] s, input logic [7:0] d);
      @(negedge sys_clk);
      acc_addr = a;
      if (a >= 8'h03 && a <= 8'h05) slot_in[a - 8'h03].reg_sel = s;
      acc_wr = 1;
      acc_wdata = d;
      @(negedge sys_clk);
      acc_wr = 0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [1:0] s, output logic [7:0] d);
      @(negedge sys_clk);
      acc_addr = a;
      if (a >= 8'h03 && a <= 8'h05) slot_in[a - 8'h03].reg_sel = s;
      repeat (2) @(negedge sys_clk);
      d = acc_rdata;
   endtask
   task automatic cnt_rise(input int k);
      repeat (40) @(negedge sys_clk);
      n = 0;
      pc = card_clk[k];
      repeat (480) begin
         @(negedge sys_clk);
         if (card_clk[k] === 1'b1 && pc === 1'b0) n++;
         pc = card_clk[k];
      end
   endtask
   task automatic end_of_test;
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (60000) @(posedge sys_clk);
      err_total++;
      end_of_test();
   end
   initial begin
      repeat (6) @(negedge sys_clk);
      rst = 0;
      rd(8'h04, 2'h1, v[0]);
      chk("short", 8'haa, v[0]);
      rd(8'h05, 2'h2, v[0]);
      chk("long high", 8'ha4, v[0]);
      rd(8'h03, 2'h3, v[0]);
      chk("long low", 8'h74, v[0]);
      rd(8'h06, 2'h1, v[0]);
      chk("unmapped", 8'h00, v[0]);
      $display("reset test done");
      for (i = 0; i < 21; i++) begin
         n = i % 3 + 1;
         v[0] = 8'($random(seed));
         wr(8'(8'h03 + i % 3), 2'(n), v[0]);
         wr(8'h07, 2'(n), ~v[0]);
         chk("preload", v[0], n == 1 ? sp : n == 2 ? lp[15:8] : lp[7:0]);
         rd(8'(8'h03 + (i + 1) % 3), 2'(n), v[1]);
         chk("counter", v[0], v[1]);
      end
      $display("counter test done");
      for (i = 0; i < 10; i++) begin
         s = i % 3;
         @(negedge sys_clk);
         slot_in[s].start = 0;
         slot_in[s].power_down_clock_select = tp[i];
         slot_in[s].atr_rst = 1'($random(seed));
         v[0] = tc[i] | (8'($random(seed)) & 8'hb0);
         wr(8'(8'h03 + s), 2'h0, v[0]);
         @(negedge sys_clk);
         slot_in[s].start = 1;
         cnt_rise(s);
         chk1("clock edges", 1'b1, edges_ok(n, tper[i]));
         if (tper[i] == 0) chk1("clock level", tl[i], card_clk[s]);
         chk1("card reset", tc[i][6] & slot_in[s].atr_rst, card_rst[s]);
         rd(8'(8'h03 + s), 2'h0, v[1]);
         chk("ctrl", exp_ctrl(v[0], !tc[i][6], tp[i]), v[1]);
      end
      slot_in[1].power_down_clock_select = 0;
      wr(8'h04, 2'h0, 8'h42);
      cnt_rise(1);
      chk1("ratio change", 1'b1, edges_ok(n, 24));
      slot_in[0].power_down_clock_select = 0;
      wr(8'h03, 2'h0, 8'h40);
      repeat (4) @(negedge sys_clk);
      chk1("sync reset", 1'b1, card_rst[0]);
      chk1("sync clock", 1'b0, card_clk[0]);
      cnt_rise(0);
      chk1("sync clock held", 1'b1, edges_ok(n, 0));
      slot_in[0].start = 0;
      repeat (4) @(negedge sys_clk);
      chk1("stop clock", 1'b0, card_clk[0]);
      chk1("stop reset", 1'b0, card_rst[0]);
      $display("clock test done");
      end_of_test();
   end
endmodule
